/* core/sram_host_pkg.sv */
// Purpose: constants for the host controller of a 256K x 1 asynchronous static ram
// Assumes: clk_i at 10 MHz; all times are whole nanoseconds
// Notes: timings are worst figures of the slowest speed grade, rounded to cycles
package sram_host_pkg;
	localparam int unsigned addr_w = 18;
	localparam int unsigned clk_period_ns = 100;
	localparam int unsigned t_access_ns = 45;
	localparam int unsigned t_write_pulse_ns = 40;
	localparam int unsigned t_out_off_ns = 20;
	localparam int unsigned t_addr_hold_ns = 2;
	// least times round up, none below one cycle
	function automatic int unsigned cyc_up(input int unsigned ns);
		int unsigned c;
		c = (ns + clk_period_ns - 1) / clk_period_ns;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int unsigned access_cyc = cyc_up(t_access_ns);
	localparam int unsigned wpulse_cyc = cyc_up(t_write_pulse_ns);
	localparam int unsigned off_cyc = cyc_up(t_out_off_ns);
	localparam int unsigned hold_cyc = cyc_up(t_addr_hold_ns);
	localparam int unsigned cnt_w = 4;
	typedef enum logic [2:0] {st_idle, st_rd, st_wr_off, st_wr_pulse, st_wr_hold} host_state_e;
endpackage

/* core/sram_cycle_timer.sv */
// Purpose: down counter that times phases of a memory cycle
// Assumes: load has priority over counting
// Notes: done is high while the count is zero
`timescale 1ns/1ps
module sram_cycle_timer #(
	parameter int unsigned W = 4
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic load_i,
	input wire logic [W-1:0] value_i,
	output logic done_o
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;
	// a zero-width count cannot time anything
	if (W < 1) begin : g_bad_w
		$error("timer width must be at least one");
	end
	// count down to zero and rest there
	always_comb begin
		next_count = count;
		if (load_i) begin
			next_count = value_i;
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
	assign done_o = (count == '0);
endmodule

/* core/sram_host_ctrl.sv */
// Purpose: host side controller issuing single-bit reads and writes to the ram
// Assumes: request is held stable until ack; the ram shares d and q on one wire
// Notes: every cycle starts and ends with select high so the address moves only idle
`timescale 1ns/1ps
module sram_host_ctrl #(
	parameter int unsigned ADDR_W = sram_host_pkg::addr_w
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic req_i,
	input wire logic req_write_i,
	input wire logic [ADDR_W-1:0] req_addr_i,
	input wire logic req_wdata_i,
	output logic ack_o,
	output logic rdata_o,
	output logic ram_sel_n_o,
	output logic ram_wr_n_o,
	output logic [ADDR_W-1:0] addr_bus_o,
	output logic ram_d_o,
	output logic ram_d_oe_o,
	input wire logic ram_q_i
);
	import sram_host_pkg::*;

	// refuse a pin map the ram does not have, and phase counts the timer cannot hold
	if (ADDR_W != addr_w) begin : g_bad_addr_w
		$error("address width must match the ram");
	end
	if ((access_cyc >= 2 ** cnt_w) || (wpulse_cyc >= 2 ** cnt_w) ||
		(off_cyc >= 2 ** cnt_w) || (hold_cyc >= 2 ** cnt_w)) begin : g_bad_cnt_w
		$error("phase count does not fit the timer");
	end

	////////////////////////////////////////////////////////////////////////
	host_state_e state, next_state;
	logic sel_n, next_sel_n;
	logic wr_n, next_wr_n;
	logic [ADDR_W-1:0] addr, next_addr;
	logic dout, next_dout;
	logic doe, next_doe;
	logic ack, next_ack;
	logic rdata, next_rdata;
	logic tload;
	logic [cnt_w-1:0] tval;
	logic tdone;

	sram_cycle_timer #(.W(cnt_w)) u_timer (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.load_i(tload),
		.value_i(tval),
		.done_o(tdone)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencing: address latched only while select is high
	always_comb begin
		next_state = state;
		next_sel_n = sel_n;
		next_wr_n = wr_n;
		next_addr = addr;
		next_dout = dout;
		next_doe = doe;
		next_ack = 1'b0;
		next_rdata = rdata;
		tload = 1'b0;
		tval = '0;
		case (state)
			st_idle: begin
				if (req_i && !ack) begin
					next_addr = req_addr_i;
					next_sel_n = 1'b0;
					tload = 1'b1;
					if (req_write_i) begin
						// strobe low with select: the device never drives, so no contention
						next_wr_n = 1'b0;
						next_dout = req_wdata_i;
						tval = cnt_w'(off_cyc);
						next_state = st_wr_off;
					end else begin
						tval = cnt_w'(access_cyc);
						next_state = st_rd;
					end
				end
			end
			st_rd: begin
				if (tdone) begin
					next_rdata = ram_q_i;
					next_sel_n = 1'b1;
					next_ack = 1'b1;
					next_state = st_idle;
				end
			end
			st_wr_off: begin
				if (tdone) begin
					next_doe = 1'b1;
					tload = 1'b1;
					tval = cnt_w'(wpulse_cyc);
					next_state = st_wr_pulse;
				end
			end
			st_wr_pulse: begin
				if (tdone) begin
					// select-ended write: output stays off and data holds two more cycles
					next_sel_n = 1'b1;
					tload = 1'b1;
					tval = cnt_w'(hold_cyc);
					next_state = st_wr_hold;
				end
			end
			st_wr_hold: begin
				if (tdone) begin
					next_wr_n = 1'b1;
					// data let go only as the strobe rises, so hold is met at either end
					next_doe = 1'b0;
					next_ack = 1'b1;
					next_state = st_idle;
				end
			end
			default: begin
				next_state = st_idle;
				next_sel_n = 1'b1;
				next_wr_n = 1'b1;
				next_doe = 1'b0;
			end
		endcase
	end

	// registers: every pin comes straight from a flip-flop
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= st_idle;
			sel_n <= 1'b1;
			wr_n <= 1'b1;
			addr <= '0;
			dout <= 1'b0;
			doe <= 1'b0;
			ack <= 1'b0;
			rdata <= 1'b0;
		end else begin
			state <= next_state;
			sel_n <= next_sel_n;
			wr_n <= next_wr_n;
			addr <= next_addr;
			dout <= next_dout;
			doe <= next_doe;
			ack <= next_ack;
			rdata <= next_rdata;
		end
	end

	assign ram_sel_n_o = sel_n;
	assign ram_wr_n_o = wr_n;
	assign addr_bus_o = addr;
	assign ram_d_o = dout;
	assign ram_d_oe_o = doe;
	assign ack_o = ack;
	assign rdata_o = rdata;

	////////////////////////////////////////////////////////////////////////
	// the address may only move at an edge where select was still high
	property p_addr_stable;
		@(posedge clk_i) disable iff (sys_rst_i)
		(!$stable(addr)) |-> $past(sel_n);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved during write");

	property p_no_drive_early;
		@(posedge clk_i) disable iff (sys_rst_i)
		($fell(wr_n)) |-> !doe [*1] ##1 !doe;
	endproperty
	a_no_drive_early: assert property (p_no_drive_early) else $error("write data driven too early");

	property p_write_ends_by_select;
		@(posedge clk_i) disable iff (sys_rst_i)
		($rose(sel_n) && !wr_n) |-> doe;
	endproperty
	a_write_ends_by_select: assert property (p_write_ends_by_select) else $error("data not held at write end");

	property p_strobe_not_late;
		@(posedge clk_i) disable iff (sys_rst_i)
		($fell(wr_n)) |-> $fell(sel_n);
	endproperty
	a_strobe_not_late: assert property (p_strobe_not_late) else $error("strobe fell after select");

	property p_read_len;
		@(posedge clk_i) disable iff (sys_rst_i)
		($fell(sel_n) && wr_n) |-> !sel_n [*2] ##1 sel_n ##0 ack;
	endproperty
	a_read_len: assert property (p_read_len) else $error("read cycle length wrong");

	// the ack cycle finds the ram deselected and the wire released
	property p_ack_idle;
		@(posedge clk_i) disable iff (sys_rst_i)
		ack |-> sel_n && wr_n && !doe;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ram not released at ack");

	property p_strobe_rise;
		@(posedge clk_i) disable iff (sys_rst_i)
		$rose(wr_n) |-> $past(doe) && sel_n;
	endproperty
	a_strobe_rise: assert property (p_strobe_rise) else $error("data not held to strobe rise");

	property p_read_quiet;
		@(posedge clk_i) disable iff (sys_rst_i)
		(state == st_rd) |-> wr_n && !doe;
	endproperty
	a_read_quiet: assert property (p_read_quiet) else $error("strobe or data active in a read");

	property p_data_in_write;
		@(posedge clk_i) disable iff (sys_rst_i)
		$rose(doe) |-> !wr_n && !sel_n;
	endproperty
	a_data_in_write: assert property (p_data_in_write) else $error("data driven outside a write");
endmodule

/* tb/sram_model.sv */
// Purpose: behavioural 256K x 1 ram on the far side of the host controller
// Assumes: d and q share one wire outside this model
// Notes: undriven output shows the inverse of its last driven level
`timescale 1ns/1ps
module sram_model (
	input wire logic sel_n_i,
	input wire logic wr_n_i,
	input wire logic [17:0] addr_bus_i,
	input wire logic d_i,
	output logic q_o,
	output logic q_oe_o
);
	logic mem [0:262143];
	logic last = 1'b0;
	logic wr_act = 1'b0;
	////////////////////////////////////////////////////////////////
	// write opens at the later falling edge of select or strobe
	always @(negedge sel_n_i or negedge wr_n_i) begin
		if (!sel_n_i && !wr_n_i) wr_act = 1'b1;
	end
	// bit at the terminating edge is kept; reads never touch the array
	always @(posedge sel_n_i or posedge wr_n_i) begin
		if (wr_act) mem[addr_bus_i] = d_i;
		wr_act = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// drives only in a read; off at once when strobe falls
	assign q_oe_o = !sel_n_i && wr_n_i;
	always @* begin
		if (q_oe_o) last = mem[addr_bus_i];
	end
	// same access delay from address or select, whatever the idle time
	assign #45 q_o = q_oe_o ? mem[addr_bus_i] : ~last;
endmodule

/* tb/tb.sv */
// Purpose: bench for the ram host controller
// Assumes: clk_i at 10 MHz, model ram on the shared wire
// Notes: latencies follow the one-cycle timer counts
`timescale 1ns/1ps
module tb;
	logic clk_i = 0, sys_rst_i = 1, req_i = 0, req_write_i = 0, req_wdata_i = 0;
	logic [17:0] req_addr_i = 0, addr_bus, prev = 0;
	logic ack_o, rdata_o, sel_n, wr_n, d, oe, q, q_oe, wire_v, pact = 0;
	logic [17:0] at [4] = '{18'h00000, 18'h3ffff, 18'h155aa, 18'h2aa55};
	int errors = 0, tests_run = 0;
	always #50 clk_i = ~clk_i;
	// host wins the wire only while it enables its driver
	assign wire_v = oe ? d : q;
	sram_host_ctrl uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .req_write_i(req_write_i),
		.req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .ack_o(ack_o), .rdata_o(rdata_o),
		.ram_sel_n_o(sel_n), .ram_wr_n_o(wr_n), .addr_bus_o(addr_bus), .ram_d_o(d), .ram_d_oe_o(oe),
		.ram_q_i(wire_v));
	sram_model ram (.sel_n_i(sel_n), .wr_n_i(wr_n), .addr_bus_i(addr_bus), .d_i(wire_v), .q_o(q),
		.q_oe_o(q_oe));
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one request held until ack; lat counts edges from raising req
	task automatic xfer(input logic w, input logic [17:0] a, input logic b, input int lat);
		int n;
		@(posedge clk_i);
		req_i <= 1;
		req_write_i <= w;
		req_addr_i <= a;
		req_wdata_i <= b;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		req_i <= 0;
		if (n >= 20) begin
			errors++;
			test_done;
		end
		check("cycles", n, lat);
	endtask
	////////////////////////////////////////////////////////////////
	// a moving address under a live write or a fight on the wire is a fault
	always @(posedge clk_i) begin
		if (oe && q_oe) check("contention", 1, 0);
		if (!sel_n && !wr_n && pact) check("addr_held", addr_bus, prev);
		prev <= addr_bus;
		pact <= !sel_n && !wr_n;
	end
	task automatic t_fill;
		for (int i = 0; i < 4; i++) xfer(1, at[i], i[0], 8);
		for (int i = 3; i >= 0; i--) begin
			xfer(0, at[i], 0, 4);
			check("rdata", rdata_o, i[0]);
		end
	endtask
	task automatic t_over;
		xfer(1, at[1], 0, 8);
		xfer(0, at[1], 0, 4);
		check("rdata_over", rdata_o, 0);
		xfer(0, at[3], 0, 4);
		check("rdata_other", rdata_o, 1);
	endtask
	// host reset cut into a live write must free the ram and keep other cells
	task automatic t_rst;
		@(posedge clk_i);
		req_i <= 1;
		req_write_i <= 1;
		req_addr_i <= at[2];
		req_wdata_i <= 1;
		repeat (4) @(posedge clk_i);
		check("sel_mid", sel_n, 0);
		check("oe_mid", oe, 1);
		sys_rst_i <= 1;
		req_i <= 0;
		repeat (2) @(posedge clk_i);
		check("sel_n", sel_n, 1);
		check("wr_n", wr_n, 1);
		check("oe", oe, 0);
		sys_rst_i <= 0;
		xfer(0, at[3], 0, 4);
		check("rdata_kept", rdata_o, 1);
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 0;
		t_fill;
		t_over;
		t_rst;
		test_done;
	end
endmodule
